// [shared/serial_link_consts.svh]
/*
  Constants of the host serial link and bus listen filter: baud rates,
  oversampling, special bus addresses and frame sizes.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef SERIAL_LINK_CONSTS_SVH
`define SERIAL_LINK_CONSTS_SVH

// -----------------------------------------------------------------
// serial timing
// -----------------------------------------------------------------
`define CLK_HZ_DEFAULT   200000000
`define OVERSAMPLE       16
`define MID_TICK         4'h7
`define LAST_TICK        4'hf
`define BAUD_SEL_MAX     4'hd
`define BAUD_SEL_DEFAULT 4'hc

// selectable bit rates, bits per second, in selector order 0..13
`define BAUD_0  50
`define BAUD_1  75
`define BAUD_2  150
`define BAUD_3  200
`define BAUD_4  300
`define BAUD_5  600
`define BAUD_6  1200
`define BAUD_7  1800
`define BAUD_8  2400
`define BAUD_9  3600
`define BAUD_10 4800
`define BAUD_11 7200
`define BAUD_12 9600
`define BAUD_13 19200

// -----------------------------------------------------------------
// character layout
// -----------------------------------------------------------------
`define DATA_BITS_SHORT  3'h6
`define DATA_BITS_LONG   3'h7

// -----------------------------------------------------------------
// instrument bus addresses
// -----------------------------------------------------------------
`define UNLISTEN_ADDR    5'h1f
`define CONTROLLER_ADDR  5'h00

`endif

// [shared/serial_link_pkg.sv]
/*
  Types of the host serial link: parity modes, state encodings and the
  packed carriers for configuration and received words.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_link_pkg;

  typedef enum logic [2:0] {
    PAR_NONE = 3'b000,
    PAR_ZERO = 3'b001,
    PAR_EVEN = 3'b010,
    PAR_ODD  = 3'b011,
    PAR_ONE  = 3'b100
  } parity_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100
  } frame_state_t;

  typedef struct packed {
    logic [3:0] baud_sel;   // 0..13, see rate table
    logic       data8;      // 1: eight data bits, 0: seven
    parity_t    parity;
    logic       two_stop;   // 1: two stop bits on transmit
  } serial_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
    logic       frame_err;
  } rx_word_t;

endpackage

// [core/word_buffer.sv]
/*
  Small FIFO with valid/ready on both sides; status flags are registered.
  Assumes a single clock and that both neighbours follow valid/ready.
*/
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,       // system clock
  input  wire logic             rstn,      // async reset, active low
  input  wire logic             in_valid,  // write request
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  in_ready,  // space available
  output logic                  out_valid, // word available
  output logic [WIDTH-1:0]      out_data,  // head word
  input  wire logic             out_ready  // reader takes head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("word_buffer depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             full_reg;
  logic             empty_reg;

  wire push = in_valid && !full_reg;
  wire pop  = out_ready && !empty_reg;

  assign count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
  assign in_ready   = !full_reg;
  assign out_valid  = !empty_reg;
  assign out_data   = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      full_reg   <= 1'b0;
      empty_reg  <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg  <= count_next;
      full_reg   <= (count_next == (AW + 1)'(DEPTH));
      empty_reg  <= (count_next == '0);
    end
  end
endmodule

// [core/host_serial_link.sv]
/*
  Remote-control front end: a configurable asynchronous serial port
  (rate, 7/8 data bits, five parity modes, 1/2 stop bits) and the listen
  filter for the parallel instrument bus.
  Assumes config ports come from logic on clk, rxd is an asynchronous
  pin, and bus address/data strobes are already on clk.
*/
`timescale 1ns/1ps
`include "serial_link_consts.svh"

// Behaviour
// - own address received: accept following bus data
// - foreign address: discard data until own again
// - bus address is five bits, 0 to 31
// - address 31 unlistens, never enables listening
// - fourteen selectable rates, 50 to 19200 bit/s
// - seven or eight data bits per character
// - parity: none, zero, even, odd, one
// - even/odd parity counts data plus parity ones
// - transmit one or two stop bits
module host_serial_link #(
  parameter int CLK_HZ    = `CLK_HZ_DEFAULT,
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                        clk,            // 200 MHz system clock
  input  wire logic                        rstn,           // async reset, active low
  input  wire serial_link_pkg::serial_cfg_t cfg,           // serial settings
  input  wire logic [4:0]                  own_addr,       // device bus address
  input  wire logic                        rxd,            // serial input pin
  output logic                             txd,            // serial output pin
  input  wire logic                        tx_valid,       // character to send
  input  wire logic [7:0]                  tx_data,        // character data
  output logic                             tx_ready,       // transmitter idle
  output logic                             rx_valid,       // received word waiting
  output serial_link_pkg::rx_word_t        rx_word,        // data with error flags
  input  wire logic                        rx_ready,       // consumer takes word
  output logic                             rx_overrun,     // sticky: word dropped
  input  wire logic                        rx_overrun_clr, // clears rx_overrun
  input  wire logic                        bus_addr_valid, // address strobe
  input  wire logic [4:0]                  bus_addr,       // received address
  input  wire logic                        bus_data_valid, // data strobe
  input  wire logic [7:0]                  bus_data,       // received bus data
  output logic                             listening,      // addressed as listener
  output logic                             cmd_valid,      // accepted bus data pulse
  output logic [7:0]                       cmd_data        // accepted bus data
);
  generate
    if (CLK_HZ < `OVERSAMPLE * `BAUD_13 ||
        CLK_HZ / (`OVERSAMPLE * `BAUD_0) > 20'hfffff) begin : g_bad_clk
      $error("clock outside what the rate divider can serve");
    end
  endgenerate

  // -----------------------------------------------------------------
  // bus listen filter
  // -----------------------------------------------------------------
  logic       listen_reg;
  logic       cmd_valid_reg;
  logic [7:0] cmd_data_reg;

  // 31 is unlisten even if own_addr was set to 31
  wire addr_is_own = (bus_addr == own_addr) && (bus_addr != `UNLISTEN_ADDR);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      listen_reg    <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_data_reg  <= 8'h00;
    end else begin
      if (bus_addr_valid) begin
        listen_reg <= addr_is_own;
      end
      cmd_valid_reg <= bus_data_valid && listen_reg;
      if (bus_data_valid && listen_reg) begin
        cmd_data_reg <= bus_data;
      end
    end
  end

  assign listening = listen_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_data  = cmd_data_reg;

  // -----------------------------------------------------------------
  // rate generator: one enable pulse per sixteenth of a bit
  // -----------------------------------------------------------------
  localparam int RATE_TAB [14] = '{`BAUD_0, `BAUD_1, `BAUD_2, `BAUD_3, `BAUD_4, `BAUD_5,
                                   `BAUD_6, `BAUD_7, `BAUD_8, `BAUD_9, `BAUD_10,
                                   `BAUD_11, `BAUD_12, `BAUD_13};

  // unused selectors 14 and 15 fall back to 9600
  function automatic logic [19:0] tick_div(input logic [3:0] sel);
    int rate;
    rate = (sel > `BAUD_SEL_MAX) ? `BAUD_12 : RATE_TAB[sel];
    tick_div = 20'(CLK_HZ / (`OVERSAMPLE * rate));
  endfunction

  logic [19:0] div_cnt_reg;
  logic        tick_reg;
  wire  [19:0] div_limit = tick_div(cfg.baud_sel);
  wire  [19:0] div_inc   = div_cnt_reg + 20'h00001;
  wire         div_wrap  = (div_inc >= div_limit);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 20'h00000;
      tick_reg    <= 1'b0;
    end else begin
      tick_reg    <= div_wrap;
      div_cnt_reg <= div_wrap ? 20'h00000 : div_inc;
    end
  end

  // -----------------------------------------------------------------
  // shared character layout
  // -----------------------------------------------------------------
  wire [2:0] last_bit   = cfg.data8 ? `DATA_BITS_LONG : `DATA_BITS_SHORT;
  wire       has_parity = (cfg.parity != serial_link_pkg::PAR_NONE);

  function automatic logic parity_of(input logic [7:0] d, input logic d8,
                                     input serial_link_pkg::parity_t p);
    logic ones;
    ones = ^(d8 ? d : {1'b0, d[6:0]});
    case (p)
      serial_link_pkg::PAR_ZERO: parity_of = 1'b0;
      serial_link_pkg::PAR_EVEN: parity_of = ones;
      serial_link_pkg::PAR_ODD:  parity_of = ~ones;
      serial_link_pkg::PAR_ONE:  parity_of = 1'b1;
      default:                   parity_of = 1'b0;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // transmitter
  // -----------------------------------------------------------------
  serial_link_pkg::frame_state_t tx_state_reg;
  logic [3:0] tx_tick_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic       tx_stop2_reg;
  logic       txd_reg;
  logic       tx_ready_reg;

  wire tx_bit_end = tick_reg && (tx_tick_reg == `LAST_TICK);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg <= serial_link_pkg::ST_IDLE;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_stop2_reg <= 1'b0;
      txd_reg      <= 1'b1;
      tx_ready_reg <= 1'b1;
    end else begin
      if (tick_reg) begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
      end
      case (tx_state_reg)
        serial_link_pkg::ST_IDLE: begin
          txd_reg <= 1'b1;
          if (tx_valid && tx_ready_reg) begin
            tx_ready_reg <= 1'b0;
            tx_shift_reg <= tx_data;
            tx_bit_reg   <= 3'h0;
            tx_tick_reg  <= 4'h0;
            tx_stop2_reg <= cfg.two_stop;
            txd_reg      <= 1'b0;
            tx_state_reg <= serial_link_pkg::ST_START;
          end
        end
        serial_link_pkg::ST_START: begin
          if (tx_bit_end) begin
            txd_reg      <= tx_shift_reg[0];
            tx_state_reg <= serial_link_pkg::ST_DATA;
          end
        end
        serial_link_pkg::ST_DATA: begin
          if (tx_bit_end) begin
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == last_bit) begin
              txd_reg      <= has_parity ? parity_of(tx_shift_reg, cfg.data8, cfg.parity)
                                         : 1'b1;
              tx_state_reg <= has_parity ? serial_link_pkg::ST_PARITY
                                         : serial_link_pkg::ST_STOP;
            end else begin
              txd_reg <= tx_shift_reg[tx_bit_reg + 3'h1];
            end
          end
        end
        serial_link_pkg::ST_PARITY: begin
          if (tx_bit_end) begin
            txd_reg      <= 1'b1;
            tx_state_reg <= serial_link_pkg::ST_STOP;
          end
        end
        serial_link_pkg::ST_STOP: begin
          if (tx_bit_end) begin
            if (tx_stop2_reg) begin
              tx_stop2_reg <= 1'b0;
            end else begin
              tx_ready_reg <= 1'b1;
              tx_state_reg <= serial_link_pkg::ST_IDLE;
            end
          end
        end
        default: tx_state_reg <= serial_link_pkg::ST_IDLE;
      endcase
    end
  end

  assign txd      = txd_reg;
  assign tx_ready = tx_ready_reg;

  // -----------------------------------------------------------------
  // receiver input: three stages, a level counts once stages 2 and 3 agree
  // -----------------------------------------------------------------
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_s3_reg;
  logic rx_level_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_reg    <= 1'b1;
      rx_s2_reg    <= 1'b1;
      rx_s3_reg    <= 1'b1;
      rx_level_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rxd;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        rx_level_reg <= rx_s3_reg;
      end
    end
  end

  // -----------------------------------------------------------------
  // receiver: samples mid-bit, one stop bit checked
  // -----------------------------------------------------------------
  serial_link_pkg::frame_state_t rx_state_reg;
  logic [3:0] rx_tick_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic       rx_perr_reg;
  logic       rx_push_reg;
  logic       overrun_reg;
  serial_link_pkg::rx_word_t rx_out_reg;
  logic       buf_in_ready;

  wire rx_mid   = tick_reg && (rx_tick_reg == `MID_TICK);
  wire rx_late  = tick_reg && (rx_tick_reg == `LAST_TICK);
  wire rx_drop  = rx_push_reg && !buf_in_ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state_reg <= serial_link_pkg::ST_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_perr_reg  <= 1'b0;
      rx_push_reg  <= 1'b0;
      rx_out_reg   <= '0;
      overrun_reg  <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      // a drop in the clearing cycle still leaves the flag set
      overrun_reg <= rx_drop || (overrun_reg && !rx_overrun_clr);
      if (tick_reg) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
      end
      case (rx_state_reg)
        serial_link_pkg::ST_IDLE: begin
          if (!rx_level_reg) begin
            rx_tick_reg  <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_state_reg <= serial_link_pkg::ST_START;
          end
        end
        serial_link_pkg::ST_START: begin
          if (rx_mid) begin
            rx_tick_reg  <= 4'h0;
            rx_state_reg <= rx_level_reg ? serial_link_pkg::ST_IDLE
                                         : serial_link_pkg::ST_DATA;
          end
        end
        serial_link_pkg::ST_DATA: begin
          if (rx_late) begin
            rx_shift_reg[rx_bit_reg] <= rx_level_reg;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit) begin
              rx_state_reg <= has_parity ? serial_link_pkg::ST_PARITY
                                         : serial_link_pkg::ST_STOP;
            end
          end
        end
        serial_link_pkg::ST_PARITY: begin
          if (rx_late) begin
            rx_perr_reg  <= rx_level_reg !=
                            parity_of(rx_shift_reg, cfg.data8, cfg.parity);
            rx_state_reg <= serial_link_pkg::ST_STOP;
          end
        end
        serial_link_pkg::ST_STOP: begin
          if (rx_late) begin
            rx_out_reg.data       <= rx_shift_reg;
            rx_out_reg.parity_err <= has_parity && rx_perr_reg;
            rx_out_reg.frame_err  <= !rx_level_reg;
            rx_push_reg  <= 1'b1;
            rx_perr_reg  <= 1'b0;
            rx_state_reg <= serial_link_pkg::ST_IDLE;
          end
        end
        default: rx_state_reg <= serial_link_pkg::ST_IDLE;
      endcase
    end
  end

  assign rx_overrun = overrun_reg;

  // a slow consumer loses nothing while the buffer has room
  word_buffer #(
    .WIDTH ($bits(serial_link_pkg::rx_word_t)),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buffer (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (rx_push_reg),
    .in_data   (rx_out_reg),
    .in_ready  (buf_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_word),
    .out_ready (rx_ready)
  );
endmodule

// [testbench/host_serial_link_sva.sv]
/*
  Checker for host_serial_link: listen filter, transmit framing, rx buffer.
  Assumes binding to the top module; sees only its ports.
*/
`timescale 1ns/1ps
module host_serial_link_sva (
  input wire logic                         clk,            // clock
  input wire logic                         rstn,           // reset, active low
  input wire serial_link_pkg::serial_cfg_t cfg,            // settings
  input wire logic [4:0]                   own_addr,       // own bus address
  input wire logic                         txd,            // serial out
  input wire logic                         tx_valid,       // send request
  input wire logic                         tx_ready,       // sender idle
  input wire logic                         rx_valid,       // word waiting
  input wire serial_link_pkg::rx_word_t    rx_word,        // head word
  input wire logic                         rx_ready,       // reader pops
  input wire logic                         bus_addr_valid, // address strobe
  input wire logic [4:0]                   bus_addr,       // address
  input wire logic                         bus_data_valid, // data strobe
  input wire logic [7:0]                   bus_data,       // data
  input wire logic                         listening,      // listener state
  input wire logic                         cmd_valid,      // accepted pulse
  input wire logic [7:0]                   cmd_data        // accepted data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // -----------------------------------------------------------------
  // listen filter
  // -----------------------------------------------------------------
  a_own_listen: assert property (bus_addr_valid && bus_addr == own_addr && bus_addr != 5'h1f
    |=> listening) else $error("own address did not enable listening");
  a_zero_addr_ok: assert property (bus_addr_valid && bus_addr == 5'h00 && own_addr == 5'h00
    |=> listening) else $error("address zero refused");
  a_foreign_drop: assert property (bus_addr_valid && bus_addr != own_addr |=> !listening)
    else $error("foreign address left listening on");
  a_unlisten_code: assert property (bus_addr_valid && bus_addr == 5'h1f |=> !listening)
    else $error("unlisten code enabled listening");
  a_listen_holds: assert property (!bus_addr_valid |=> $stable(listening))
    else $error("listening changed without address");
  a_cmd_accept: assert property (bus_data_valid && listening
    |=> cmd_valid && cmd_data == $past(bus_data)) else $error("accepted data wrong");
  a_cmd_refused: assert property (!(bus_data_valid && listening) |=> !cmd_valid)
    else $error("data passed while not listening");

  // -----------------------------------------------------------------
  // serial side
  // -----------------------------------------------------------------
  a_tx_start_low: assert property (tx_valid && tx_ready |=> !txd && !tx_ready)
    else $error("start bit missing");
  a_tx_idle_high: assert property (tx_ready |-> txd)
    else $error("line not high while idle");
  a_tx_frame_busy: assert property ($fell(tx_ready) |-> !tx_ready [*8])
    else $error("frame ended too early");
  a_rx_word_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
    else $error("waiting word changed");
  a_rx_seven_bit: assert property (rx_valid && !cfg.data8 |-> !rx_word.data[7])
    else $error("seven bit word has bit seven set");

  c_listen: cover property ($rose(listening));
  c_cmd: cover property (bus_data_valid && listening);
  c_tx: cover property ($fell(tx_ready));
  c_perr: cover property (rx_valid && rx_word.parity_err);
endmodule

bind host_serial_link host_serial_link_sva chk (
  .clk(clk), .rstn(rstn), .cfg(cfg), .own_addr(own_addr), .txd(txd), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready),
  .bus_addr_valid(bus_addr_valid), .bus_addr(bus_addr), .bus_data_valid(bus_data_valid),
  .bus_data(bus_data), .listening(listening), .cmd_valid(cmd_valid), .cmd_data(cmd_data));

// [testbench/serial_host_model.sv]
/*
  Host at the far end of the serial line: sends and decodes characters.
  Assumes the caller passes the bit time in clocks and matching settings.
*/
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic clk, // system clock
  output logic      rxd, // line into the device
  input  wire logic txd  // line out of the device
);
  initial rxd = 1'b1;

  function automatic logic pbit(input logic [7:0] d, input int nd, input int par);
    logic x;
    x = ^((nd == 8) ? d : {1'b0, d[6:0]});
    // even keeps the count of ones even, odd makes it odd
    return (par == 1) ? 1'b0 : (par == 2) ? x : (par == 3) ? ~x : 1'b1;
  endfunction

  // host uses the same settings as the device
  task automatic send(input logic [7:0] d, input int nd, input int par, input int bitc,
                      input bit flip);
    int i;
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bitc) @(posedge clk);
    for (i = 0; i < nd; i++) begin
      rxd <= d[i];
      repeat (bitc) @(posedge clk);
    end
    if (par != 0) begin
      rxd <= pbit(d, nd, par) ^ flip;
      repeat (bitc) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bitc) @(posedge clk);
  endtask

  task automatic recv(input int nd, input int par, input int bitc, output logic [7:0] d,
                      output logic p, output logic s);
    int i;
    d = 8'h00;
    p = 1'b0;
    @(negedge txd);
    repeat (bitc / 2) @(posedge clk);
    for (i = 0; i < nd; i++) begin
      repeat (bitc) @(posedge clk);
      d[i] = txd;
    end
    if (par != 0) begin
      repeat (bitc) @(posedge clk);
      p = txd;
    end
    repeat (bitc) @(posedge clk);
    s = txd;
  endtask
endmodule

// [testbench/tb_host_serial_link.sv]
/*
  Self-checking bench for host_serial_link with a reference model.
  Assumes serial_host_model on the line and a reduced clock parameter.
*/
`timescale 1ns/1ps
module tb_host_serial_link;
  logic                         clk, rstn, rxd, txd, tx_valid, tx_ready, rx_valid, rx_ready;
  logic                         rx_overrun, rx_overrun_clr, bus_addr_valid, bus_data_valid;
  logic                         listening, cmd_valid, lst, ecmd, av, dv;
  logic [4:0]                   own_addr, bus_addr, o, ad;
  logic [7:0]                   tx_data, bus_data, cmd_data, edat, dt;
  logic [15:0]                  rnd;
  logic [9:0]                   exp_q[$];
  serial_link_pkg::serial_cfg_t cfg;
  serial_link_pkg::rx_word_t    rx_word;
  int                           fails, comparisons, i, k;
  int                           rate_tab[3] = '{7200, 9600, 19200};

  host_serial_link #(.CLK_HZ(3200000)) dut (
    .clk(clk), .rstn(rstn), .cfg(cfg), .own_addr(own_addr), .rxd(rxd), .txd(txd),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
    .rx_overrun_clr(rx_overrun_clr), .bus_addr_valid(bus_addr_valid), .bus_addr(bus_addr),
    .bus_data_valid(bus_data_valid), .bus_data(bus_data), .listening(listening),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data));
  serial_host_model host (.clk(clk), .rxd(rxd), .txd(txd));

  always #2.5 clk = ~clk;

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  task automatic test_done();
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // serial helpers
  // -----------------------------------------------------------------
  task automatic tx_case(input int par, input bit d8, input bit two, input int sel);
    int         bitc, n, nd, bits;
    logic [7:0] dat, rd;
    logic       rp, rs;
    bitc = 16 * (3200000 / (16 * rate_tab[sel - 11]));
    nd = d8 ? 8 : 7;
    bits = 2 + nd + (par != 0) + two;
    dat = rnd[7:0];
    rnd = step(rnd);
    n = 0;
    @(posedge clk);
    cfg <= serial_link_pkg::serial_cfg_t'({sel[3:0], d8, par[2:0], two});
    @(posedge clk);
    tx_data <= dat;
    tx_valid <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    fork
      host.recv(nd, par, bitc, rd, rp, rs);
      while ((tx_ready !== 1'b1 || n == 0) && n < 20000) begin
        @(posedge clk);
        n++;
      end
    join
    chk("tx_data", d8 ? dat : {1'b0, dat[6:0]}, rd);
    chk("tx_parity", (par != 0) ? host.pbit(dat, nd, par) : 1'b0, rp);
    chk("tx_stop", 1, rs);
    chk("tx_length", 1, n >= bits * bitc - bitc / 16 - 4 && n <= bits * bitc + 4);
  endtask

  task automatic rx_send(input bit flip);
    logic [7:0] dat;
    int         nd, par;
    nd = cfg.data8 ? 8 : 7;
    par = int'(cfg.parity);
    dat = rnd[7:0];
    rnd = step(rnd);
    exp_q.push_back({(nd == 8) ? dat : {1'b0, dat[6:0]}, flip && par != 0, 1'b0});
    host.send(dat, nd, par, 160, flip);
  endtask

  task automatic pop();
    int n;
    n = 0;
    @(posedge clk);
    while (rx_valid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("rx_word", {1'b1, exp_q.pop_front()}, {rx_valid, rx_word});
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    {clk, rstn, tx_valid, rx_ready, rx_overrun_clr, bus_addr_valid, bus_data_valid} = '0;
    {tx_data, bus_data, bus_addr, own_addr, edat} = '0;
    cfg = serial_link_pkg::serial_cfg_t'(9'h1b0);
    {fails, comparisons, lst, ecmd} = '0;
    rnd = 16'h0020;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("reset_out", 7'h60, {txd, tx_ready, listening, rx_valid, cmd_valid, rx_overrun, |cmd_data});
    for (k = 0; k < 3; k++) begin
      rnd = step(rnd);
      o = (k == 0) ? {1'b0, rnd[3:0]} + 5'h01 : (k == 1) ? 5'h00 : 5'h1f;
      @(posedge clk);
      own_addr <= o;
      for (i = 0; i <= 80; i++) begin
        av = rnd[0] && i < 80;
        dv = rnd[1] && i < 80;
        ad = rnd[2] ? o : (rnd[3] ? 5'h1f : rnd[8:4]);
        dt = rnd[15:8];
        rnd = step(rnd);
        @(posedge clk);
        {bus_addr_valid, bus_data_valid, bus_addr, bus_data} <= {av, dv, ad, dt};
        #1;
        chk("listening", lst, listening);
        chk("cmd_valid", ecmd, cmd_valid);
        chk("cmd_data", edat, cmd_data);
        ecmd = dv && lst;
        if (ecmd) edat = dt;
        if (av) lst = (ad == o) && (ad != 5'h1f);
      end
    end
    for (i = 0; i < 7; i++) tx_case(i % 5, i[0], i[1], (i < 5) ? 13 : 17 - i);
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      cfg <= serial_link_pkg::serial_cfg_t'({4'hd, i[0], i[2:0], 1'b0});
      @(posedge clk);
      rx_send(i == 3);
      pop();
    end
    // third word meets a full two-entry buffer and is dropped
    rx_send(0);
    rx_send(0);
    rx_send(0);
    repeat (40) @(posedge clk);
    chk("rx_overrun", 1, rx_overrun);
    void'(exp_q.pop_back());
    pop();
    pop();
    repeat (3) @(posedge clk);
    chk("rx_valid", 0, rx_valid);
    rx_overrun_clr <= 1'b1;
    @(posedge clk);
    rx_overrun_clr <= 1'b0;
    @(posedge clk);
    #1;
    chk("rx_overrun", 0, rx_overrun);
    test_done();
  end

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
